// ---- rtl/ncsib_top.sv ----
/*
  main control/status register bit bank of a network controller:
  event flags, interrupt summary and allow, rx/tx active indicators.
  assumes the ring engine supplies one-cycle event strobes and sees
  halt/run/setup through the outputs here; error flags come in ready.
*/
module ncsib_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [1:0]  reg_sel,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  input  wire logic        tx_final_wb,
  input  wire logic        tx_fail_stop,
  input  wire logic        rx_final_wb,
  input  wire logic        rx_fail_stop,
  input  wire logic        setup_finished,
  input  wire logic        receive_disable_option,
  input  wire logic        transmit_disable_option,
  input  wire logic        underflow_flag,
  input  wire logic        descriptor_chain_error,
  input  wire logic        retry_exhausted_flag,
  input  wire logic        overlong_transmit_flag,
  input  wire logic        missed_frame_flag,
  input  wire logic        collision_flag,
  input  wire logic        dma_timeout_flag,
  input  wire logic        tx_demand_ack,
  output logic             halt_bit,
  output logic             run_bit,
  output logic             setup_req,
  output logic             irq_req
);
  import ncsib_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire main_wr = wr_en && (reg_sel == MAIN_SEL);
  wire wr_halt = main_wr && wr_data[BIT_HALT];
  wire wr_run  = main_wr && wr_data[BIT_RUN] && !wr_data[BIT_HALT];
  wire wr_setup = main_wr && wr_data[BIT_SETUP_REQ] && !wr_data[BIT_HALT];
  // halt edge: the moment every other bit is wiped
  wire halt_set = wr_halt;

  ////////////////////////////////////////////////////////////////////////
  // event flags
  logic transmit_event;
  logic receive_event;
  logic setup_complete;
  logic tx_demand_reg;
  logic receiver_active_reg;
  logic transmitter_active_reg;
  logic irq_allow_reg;
  logic run_reg;
  logic setup_req_reg;
  logic halt_reg;

  ncsib_flag u_tx_event (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .set_ev   (tx_final_wb || tx_fail_stop),
    .wr_clear (main_wr && wr_data[BIT_TX_EVENT]),
    .halt_clr (halt_set),
    .flag_q   (transmit_event)
  );

  ncsib_flag u_rx_event (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .set_ev   (rx_final_wb || rx_fail_stop),
    .wr_clear (main_wr && wr_data[BIT_RX_EVENT]),
    .halt_clr (halt_set),
    .flag_q   (receive_event)
  );

  // only a finish of a sequence actually requested counts
  ncsib_flag u_setup_done (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .set_ev   (setup_finished && setup_req_reg),
    .wr_clear (main_wr && wr_data[BIT_SETUP_DONE]),
    .halt_clr (halt_set),
    .flag_q   (setup_complete)
  );

  ////////////////////////////////////////////////////////////////////////
  // summary and interrupt
  // error flags are masked by halt since their owner clears them later
  wire err_live = !halt_reg;
  wire irq_summary = (err_live && (overlong_transmit_flag ||
                      missed_frame_flag || dma_timeout_flag)) ||
                     receive_event || transmit_event ||
                     setup_complete;
  wire err_summary = err_live && (overlong_transmit_flag ||
                     collision_flag || missed_frame_flag ||
                     dma_timeout_flag);

  logic irq_allow_next;
  assign irq_allow_next = halt_set ? 1'b0 :
                          main_wr  ? wr_data[BIT_IRQ_ALLOW] :
                          irq_allow_reg;

  ////////////////////////////////////////////////////////////////////////
  // command bits
  logic halt_next;
  logic run_next;
  logic setup_req_next;
  logic tx_demand_next;
  assign halt_next = halt_set ? 1'b1 :
                     (wr_run || wr_setup) ? 1'b0 : halt_reg;
  assign run_next = halt_set ? 1'b0 : (wr_run || run_reg);
  assign setup_req_next = halt_set ? 1'b0 : (wr_setup || setup_req_reg);
  assign tx_demand_next = halt_set ? 1'b0 :
                          (main_wr && wr_data[BIT_TX_DEMAND]) ? 1'b1 :
                          tx_demand_ack ? 1'b0 : tx_demand_reg;

  ////////////////////////////////////////////////////////////////////////
  // active indicators
  // start taken only after setup completed; options sampled then
  wire start_now = wr_run && setup_complete;
  wire rx_kill = halt_set || dma_timeout_flag;
  wire tx_kill = halt_set || dma_timeout_flag || underflow_flag ||
                 descriptor_chain_error || retry_exhausted_flag;
  logic receiver_active_next;
  logic transmitter_active_next;
  assign receiver_active_next = rx_kill ? 1'b0 :
    (start_now && !receive_disable_option) ? 1'b1 :
    receiver_active_reg;
  assign transmitter_active_next = tx_kill ? 1'b0 :
    (start_now && !transmit_disable_option) ? 1'b1 :
    transmitter_active_reg;

  ////////////////////////////////////////////////////////////////////////
  // read view, writes to read-only bits fall away
  logic [15:0] rd_view;
  assign rd_view = {err_summary,
                    err_live && overlong_transmit_flag,
                    err_live && collision_flag,
                    err_live && missed_frame_flag,
                    err_live && dma_timeout_flag,
                    receive_event, transmit_event, setup_complete,
                    irq_summary, irq_allow_reg,
                    receiver_active_reg, transmitter_active_reg,
                    tx_demand_reg, halt_reg, run_reg,
                    setup_req_reg};
  // other selects are outside this bank and read zero
  wire [15:0] rd_next = (reg_sel == MAIN_SEL) ? rd_view : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      halt_reg               <= HALT_RESET;
      run_reg                <= FLAG_RESET;
      setup_req_reg          <= FLAG_RESET;
      tx_demand_reg          <= FLAG_RESET;
      irq_allow_reg          <= FLAG_RESET;
      receiver_active_reg    <= FLAG_RESET;
      transmitter_active_reg <= FLAG_RESET;
    end else if (clk_en) begin
      halt_reg               <= halt_next;
      run_reg                <= run_next;
      setup_req_reg          <= setup_req_next;
      tx_demand_reg          <= tx_demand_next;
      irq_allow_reg          <= irq_allow_next;
      receiver_active_reg    <= receiver_active_next;
      transmitter_active_reg <= transmitter_active_next;
    end
  end

  // outputs registered; irq lands on the same edge as the bits it reflects
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data   <= 16'h0000;
      halt_bit  <= HALT_RESET;
      run_bit   <= FLAG_RESET;
      setup_req <= FLAG_RESET;
      irq_req   <= FLAG_RESET;
    end else if (clk_en) begin
      rd_data   <= rd_next;
      halt_bit  <= halt_next;
      run_bit   <= run_next;
      setup_req <= setup_req_next;
      irq_req   <= irq_allow_next && irq_summary_nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // summary as it will stand after this edge, so irq tracks the bits
  logic tx_event_nx;
  logic rx_event_nx;
  logic setup_done_nx;
  logic irq_summary_nx;
  assign tx_event_nx = halt_set ? 1'b0 :
    (tx_final_wb || tx_fail_stop) ? 1'b1 :
    (main_wr && wr_data[BIT_TX_EVENT]) ? 1'b0 : transmit_event;
  assign rx_event_nx = halt_set ? 1'b0 :
    (rx_final_wb || rx_fail_stop) ? 1'b1 :
    (main_wr && wr_data[BIT_RX_EVENT]) ? 1'b0 : receive_event;
  assign setup_done_nx = halt_set ? 1'b0 :
    (setup_finished && setup_req_reg) ? 1'b1 :
    (main_wr && wr_data[BIT_SETUP_DONE]) ? 1'b0 : setup_complete;
  assign irq_summary_nx = (!halt_next && (overlong_transmit_flag ||
                           missed_frame_flag || dma_timeout_flag)) ||
                          tx_event_nx || rx_event_nx ||
                          setup_done_nx;
endmodule : ncsib_top

// ---- rtl/ncsib_pkg.sv ----
/*
  constants of the network control/status register bit bank: field
  positions, register select code, reset values.
  assumes a single 16-bit register data port with a 2-bit select.
*/
package ncsib_pkg;
  localparam logic [1:0] MAIN_SEL        = 2'h0;
  localparam int         BIT_SETUP_REQ   = 0;
  localparam int         BIT_RUN         = 1;
  localparam int         BIT_HALT        = 2;
  localparam int         BIT_TX_DEMAND   = 3;
  localparam int         BIT_TX_ACTIVE   = 4;
  localparam int         BIT_RX_ACTIVE   = 5;
  localparam int         BIT_IRQ_ALLOW   = 6;
  localparam int         BIT_IRQ_SUMMARY = 7;
  localparam int         BIT_SETUP_DONE  = 8;
  localparam int         BIT_TX_EVENT    = 9;
  localparam int         BIT_RX_EVENT    = 10;
  localparam int         BIT_DMA_TIMEOUT = 11;
  localparam int         BIT_MISSED      = 12;
  localparam int         BIT_COLLISION   = 13;
  localparam int         BIT_OVERLONG    = 14;
  localparam int         BIT_ERR_SUMMARY = 15;
  localparam logic       HALT_RESET      = 1'b1;
  localparam logic       FLAG_RESET      = 1'b0;
endpackage : ncsib_pkg

// ---- rtl/ncsib_flag.sv ----
/*
  one sticky event flag: hardware set, write-one clear, halt clear.
  assumes set, clear and halt are on the same clock.
*/
module ncsib_flag (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic set_ev,
  input  wire logic wr_clear,
  input  wire logic halt_clr,
  output logic      flag_q
);
  import ncsib_pkg::*;
  logic flag_next;
  // halt wins; otherwise a same-cycle event beats the host clear
  assign flag_next = halt_clr ? 1'b0 :
                     set_ev   ? 1'b1 :
                     wr_clear ? 1'b0 : flag_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) flag_q <= FLAG_RESET;
    else if (clk_en) flag_q <= flag_next;
  end
endmodule : ncsib_flag

// ---- sim/ncsib_chk_asserts.sv ----
/* checker of ncsib_top, bound from tb_top.
   assumes one clock and the host keeps reg_sel at 00 most cycles. */
module ncsib_chk
  import ncsib_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [1:0]  reg_sel,
  input wire logic        wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic        tx_final_wb,
  input wire logic        tx_fail_stop,
  input wire logic        setup_finished,
  input wire logic        dma_timeout_flag,
  input wire logic        halt_bit,
  input wire logic        run_bit,
  input wire logic        setup_req,
  input wire logic        irq_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire w00 = wr_en && reg_sel == MAIN_SEL;
  wire evt = (tx_final_wb || tx_fail_stop) && !halt_bit && !w00;
  ////////////////////////////////////////////////////////////////////////
  // read data is one cycle behind, so look one edge later
  sequence s_sel; reg_sel == MAIN_SEL; endsequence
  property p_irq; $past(reg_sel) == MAIN_SEL |->
    $past(irq_req) == (rd_data[7] && rd_data[6]); endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_sum; rd_data[7] == |{rd_data[14], rd_data[12:8]}; endproperty
  a_sum: assert property (p_sum) else $error("summary wrong");
  property p_halt; w00 && wr_data[2] ##1 s_sel |=> rd_data == 16'h0004;
  endproperty
  a_halt: assert property (p_halt) else $error("halt clear");
  property p_hout; w00 && wr_data[2] |=> halt_bit && !run_bit && !setup_req;
  endproperty
  a_hout: assert property (p_hout) else $error("halt outputs");
  property p_w1c; w00 && wr_data[8] && !setup_finished ##1 s_sel |=>
    !rd_data[8]; endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed");
  property p_tev; evt ##1 s_sel |=> rd_data[9]; endproperty
  a_tev: assert property (p_tev) else $error("tx event lost");
  property p_sdn; setup_finished && setup_req && !w00 ##1 s_sel |=>
    rd_data[8]; endproperty
  a_sdn: assert property (p_sdn) else $error("setup done lost");
  property p_dma; dma_timeout_flag && !w00 ##1 s_sel |=>
    rd_data[5:4] == 2'b00; endproperty
  a_dma: assert property (p_dma) else $error("actives kept");
  property p_alw; w00 && !wr_data[6] ##1 s_sel |=> !rd_data[6]; endproperty
  a_alw: assert property (p_alw) else $error("allow kept");
endmodule : ncsib_chk

// ---- sim/ncsib_ring_model.sv ----
/* ring engine stand-in: answers a setup request after LAG cycles.
   assumes setup_req is the design's registered output. */
module ncsib_ring_model #(
  parameter int LAG = 3
) (
  input  wire logic ref_clk,
  input  wire logic setup_req,
  output logic      setup_finished
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial setup_finished = 1'b0;
  // one pulse per request, only while it stands
  always @(posedge ref_clk) begin
    setup_finished <= setup_req && cnt == LAG - 1;
    if (!setup_req) cnt <= 0;
    else if (cnt < LAG) cnt <= cnt + 1;
  end
endmodule : ncsib_ring_model

// ---- sim/tb_top.sv ----
/* self-checking bench of ncsib_top.
   assumes ring model answers setup; inputs driven 1 ns after edges. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ncsib_pkg::*;
  logic ref_clk = 1'b0, rst_n, wr_en, rxd, dack;
  logic [1:0] reg_sel;
  logic [15:0] wr_data, e;
  logic [6:0] ev;
  logic [3:0] err;
  wire [15:0] rd_data;
  wire sfin, halt_bit, run_bit, setup_req, irq_req;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  ncsib_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_sel(reg_sel), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
    .tx_final_wb(ev[0]), .tx_fail_stop(ev[1]), .rx_final_wb(ev[2]),
    .rx_fail_stop(ev[3]), .setup_finished(sfin),
    .receive_disable_option(rxd), .transmit_disable_option(1'b0),
    .underflow_flag(ev[4]), .descriptor_chain_error(ev[5]),
    .retry_exhausted_flag(ev[6]), .overlong_transmit_flag(err[3]),
    .missed_frame_flag(err[2]), .collision_flag(err[1]),
    .dma_timeout_flag(err[0]), .tx_demand_ack(dack), .halt_bit(halt_bit),
    .run_bit(run_bit), .setup_req(setup_req), .irq_req(irq_req));
  ncsib_ring_model #(.LAG(3)) u_ring (.ref_clk(ref_clk),
    .setup_req(setup_req), .setup_finished(sfin));
  initial forever #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      close_out;
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] d);
    @(posedge ref_clk); #1;
    wr_en = 1'b1;
    wr_data = d;
    @(posedge ref_clk); #1;
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] x, input logic q);
    @(posedge ref_clk); #1;
    chk("csr", rd_data, x);
    chk("irq", {15'h0, irq_req}, {15'h0, q});
  endtask : rd
  task automatic pls(input int i);
    @(posedge ref_clk); #1;
    ev[i] = 1'b1;
    @(posedge ref_clk); #1;
    ev = 7'h0;
  endtask : pls
  // bounded poll, setup fetch length belongs to the ring side
  task automatic setup_wait;
    for (int k = 0; k < 20 && rd_data[8] !== 1'b1; k++) @(posedge ref_clk);
  endtask : setup_wait
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rxd = 1'b0;
    dack = 1'b0;
    reg_sel = MAIN_SEL;
    wr_data = 16'h0;
    ev = 7'h0;
    err = 4'h0;
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rd(16'h0004, 1'b0);
    wr(16'h0041);
    setup_wait;
    rd(16'h01c1, 1'b1);
    wr(16'h0042);
    rd(16'h01f3, 1'b1);
    wr(16'h0140);
    rd(16'h0073, 1'b0);
    $display("test setup done");
    for (int i = 0; i < 4; i++) begin
      e = (i < 2) ? 16'h02f3 : 16'h04f3;
      pls(i);
      rd(e, 1'b1);
      wr(16'h0040);
      rd(e, 1'b1);
      wr(16'h0640);
      rd(16'h0073, 1'b0);
    end
    pls(0);
    wr(16'h0000);
    rd(16'h02b3, 1'b0);
    wr(16'h0200);
    rd(16'h0033, 1'b0);
    $display("test events done");
    pls(5);
    rd(16'h0023, 1'b0);
    err = 4'h1;
    @(posedge ref_clk);
    rd(16'h8883, 1'b0);
    wr(16'h0006);
    rd(16'h0004, 1'b0);
    err = 4'h0;
    $display("test errors done");
    reg_sel = 2'h1;
    wr(16'h0002);
    rd(16'h0000, 1'b0);
    reg_sel = MAIN_SEL;
    rd(16'h0004, 1'b0);
    $display("test select done");
    rxd = 1'b1;
    wr(16'h0001);
    setup_wait;
    wr(16'h0002);
    rd(16'h0193, 1'b0);
    $display("test options done");
    wr(16'h0008);
    rd(16'h019b, 1'b0);
    dack = 1'b1;
    @(posedge ref_clk); #1;
    dack = 1'b0;
    rd(16'h0193, 1'b0);
    err = 4'h2;
    rd(16'ha193, 1'b0);
    err = 4'h0;
    $display("test demand done");
    close_out;
  end
endmodule : tb_top

bind ncsib_top ncsib_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_sel(reg_sel), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
  .tx_final_wb(tx_final_wb), .tx_fail_stop(tx_fail_stop),
  .setup_finished(setup_finished), .dma_timeout_flag(dma_timeout_flag),
  .halt_bit(halt_bit), .run_bit(run_bit), .setup_req(setup_req),
  .irq_req(irq_req));
